// ===== design/sli_indicator.sv
// Front-panel indicator controller with register port
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module sli_indicator
   import sli_pkg::*;
#(
   parameter int TICKS = TICK_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic ctrl_power_on,
   input wire logic alarm_active,
   input wire logic [3:0] alarm_count,
   input wire logic alarm_net_resettable,
   input wire logic power_removal_active,
   input wire logic info_pending,
   input wire logic teach_remote_active,
   input wire logic home_preset_sw_pin,
   input wire logic preset_func_active,
   input wire logic self_diag_active,
   input wire logic net_config_invalid,
   input wire logic ip_duplicate,
   input wire logic net_online,
   input wire logic scanner_connected,
   input wire logic scanner_timeout,
   input wire logic frame_activity,
   output logic pa_green,
   output logic pa_red,
   output logic ms_green,
   output logic ms_red,
   output logic ns_green,
   output logic ns_red,
   output logic la_led
);
   logic ms_tick;
   logic half_tick;
   logic [2:0] step;
   logic blink_on;
   logic dbl_on;

   sli_timebase #(
      .TICKS(TICKS)
   ) u_timebase (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .ms_tick(ms_tick),
      .half_tick(half_tick),
      .step_q(step)
   );

   // Blink and double blink shapes, all taken from the shared step count
   assign blink_on = ~step[0];
   assign dbl_on = (step == 3'h0) || (step == 3'h2);

   // Register port
   logic [1:0] ctrl_q, ctrl_d;
   logic [15:0] rel_time_q, rel_time_d;
   logic [31:0] rdata_d;
   logic [31:0] status_word;
   logic [31:0] inputs_word;

   always_comb begin
      ctrl_d = ctrl_q;
      rel_time_d = rel_time_q;
      if (reg_wr) begin
         unique case (reg_addr)
            CTRL_OFS: ctrl_d = reg_wdata[1:0];
            REL_TIME_OFS: rel_time_d = reg_wdata[15:0];
            default: ;
         endcase
      end
      rdata_d = 32'h0000_0000;
      if (reg_rd) begin
         unique case (reg_addr)
            CTRL_OFS: rdata_d = {30'h0, ctrl_q};
            REL_TIME_OFS: rdata_d = {16'h0000, rel_time_q};
            STATUS_OFS: rdata_d = status_word;
            INPUTS_OFS: rdata_d = inputs_word;
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= CTRL_RST;
         rel_time_q <= REL_TIME_RST;
         reg_rdata <= 32'h0000_0000;
      end else if (clk_en) begin
         ctrl_q <= ctrl_d;
         rel_time_q <= rel_time_d;
         reg_rdata <= rdata_d;
      end
   end

   // Home switch pin synchroniser and hold detection
   logic sw_meta_q, sw_sync_q;
   logic [15:0] hold_ms_q, hold_ms_d;
   logic hold_done_q, hold_done_d;
   logic [15:0] rel_left_q, rel_left_d;
   logic release_start;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         sw_meta_q <= 1'b0;
         sw_sync_q <= 1'b0;
      end else if (clk_en) begin
         sw_meta_q <= home_preset_sw_pin;
         sw_sync_q <= sw_meta_q;
      end
   end

   // A hold starts the release window once; the switch must be let go before the next
   always_comb begin
      hold_ms_d = hold_ms_q;
      hold_done_d = hold_done_q;
      release_start = 1'b0;
      if (!sw_sync_q) begin
         hold_ms_d = 16'h0000;
         hold_done_d = 1'b0;
      end else if (ms_tick && !hold_done_q) begin
         if (hold_ms_q == HOLD_MS - 16'h0001) begin
            hold_done_d = 1'b1;
            release_start = 1'b1;
         end else begin
            hold_ms_d = hold_ms_q + 16'h0001;
         end
      end
      rel_left_d = rel_left_q;
      if (release_start) begin
         rel_left_d = rel_time_q;
      end else if (ms_tick && rel_left_q != 16'h0000) begin
         rel_left_d = rel_left_q - 16'h0001;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         hold_ms_q <= 16'h0000;
         hold_done_q <= 1'b0;
         rel_left_q <= 16'h0000;
      end else if (clk_en) begin
         hold_ms_q <= hold_ms_d;
         hold_done_q <= hold_done_d;
         rel_left_q <= rel_left_d;
      end
   end

   // Alarm blink count: N red flashes, then a pause, repeated
   logic [5:0] alm_idx_q, alm_idx_d;
   logic [5:0] alm_flash;
   logic alm_on;

   always_comb begin
      alm_flash = (alarm_count == 4'h0) ? 6'h02 : {1'b0, alarm_count, 1'b0};
      alm_idx_d = alm_idx_q;
      if (!alarm_active) begin
         alm_idx_d = 6'h00;
      end else if (half_tick) begin
         if (alm_idx_q >= alm_flash + 6'(ALM_PAUSE - 1)) begin
            alm_idx_d = 6'h00;
         end else begin
            alm_idx_d = alm_idx_q + 6'h01;
         end
      end
      alm_on = (alm_idx_q < alm_flash) && !alm_idx_q[0];
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         alm_idx_q <= 6'h00;
      end else if (clk_en) begin
         alm_idx_q <= alm_idx_d;
      end
   end

   // Pattern selection and LED drive
   sli_pa_e pa_sel;
   logic pa_g_d, pa_r_d, ms_g_d, ms_r_d, ns_g_d, ns_r_d, la_d;
   logic blank;

   always_comb begin
      blank = !ctrl_power_on || ctrl_q[CTRL_BLANK_BIT];
      if (blank) begin
         pa_sel = PA_OFF;
      end else if (alarm_active) begin
         pa_sel = PA_ALARM;
      end else if (ctrl_q[CTRL_SIM_BIT]) begin
         pa_sel = PA_SIM;
      end else if (power_removal_active) begin
         pa_sel = PA_REMOVAL;
      end else if (rel_left_q != 16'h0000) begin
         pa_sel = PA_RELEASE;
      end else if (preset_func_active) begin
         pa_sel = PA_PRESET;
      end else if (info_pending || teach_remote_active) begin
         pa_sel = PA_DOUBLE;
      end else begin
         pa_sel = PA_GREEN;
      end
      unique case (pa_sel)
         PA_OFF: {pa_g_d, pa_r_d} = 2'b00;
         PA_GREEN: {pa_g_d, pa_r_d} = 2'b10;
         PA_ALARM: {pa_g_d, pa_r_d} = {1'b0, alm_on};
         PA_REMOVAL: {pa_g_d, pa_r_d} = {blink_on, 1'b0};
         PA_SIM: begin
            unique case (step[1:0])
               2'h0: {pa_g_d, pa_r_d} = 2'b10;
               2'h1: {pa_g_d, pa_r_d} = 2'b01;
               2'h2: {pa_g_d, pa_r_d} = 2'b11;
               2'h3: {pa_g_d, pa_r_d} = 2'b00;
            endcase
         end
         PA_RELEASE: {pa_g_d, pa_r_d} = {blink_on, blink_on};
         PA_PRESET: {pa_g_d, pa_r_d} = 2'b11;
         PA_DOUBLE: {pa_g_d, pa_r_d} = {dbl_on, dbl_on};
         default: {pa_g_d, pa_r_d} = 2'b00;
      endcase
      // Module status
      if (blank) begin
         {ms_g_d, ms_r_d} = 2'b00;
      end else if (self_diag_active) begin
         {ms_g_d, ms_r_d} = {blink_on, ~blink_on};
      end else if (alarm_active && !alarm_net_resettable) begin
         {ms_g_d, ms_r_d} = 2'b01;
      end else if (alarm_active || ip_duplicate) begin
         {ms_g_d, ms_r_d} = {1'b0, blink_on};
      end else if (net_config_invalid) begin
         {ms_g_d, ms_r_d} = {blink_on, 1'b0};
      end else begin
         {ms_g_d, ms_r_d} = 2'b10;
      end
      // Network status
      if (blank) begin
         {ns_g_d, ns_r_d} = 2'b00;
      end else if (self_diag_active) begin
         {ns_g_d, ns_r_d} = {blink_on, ~blink_on};
      end else if (ip_duplicate) begin
         {ns_g_d, ns_r_d} = 2'b01;
      end else if (scanner_timeout) begin
         {ns_g_d, ns_r_d} = {1'b0, blink_on};
      end else if (!net_online) begin
         {ns_g_d, ns_r_d} = 2'b00;
      end else if (scanner_connected) begin
         {ns_g_d, ns_r_d} = 2'b10;
      end else begin
         {ns_g_d, ns_r_d} = {blink_on, 1'b0};
      end
      // Link and activity
      if (blank || !net_online) begin
         la_d = 1'b0;
      end else if (frame_activity) begin
         la_d = blink_on;
      end else begin
         la_d = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pa_green <= 1'b0;
         pa_red <= 1'b0;
         ms_green <= 1'b0;
         ms_red <= 1'b0;
         ns_green <= 1'b0;
         ns_red <= 1'b0;
         la_led <= 1'b0;
      end else if (clk_en) begin
         pa_green <= pa_g_d;
         pa_red <= pa_r_d;
         ms_green <= ms_g_d;
         ms_red <= ms_r_d;
         ns_green <= ns_g_d;
         ns_red <= ns_r_d;
         la_led <= la_d;
      end
   end

   assign status_word = {12'h000, 4'(pa_sel), 9'h000, la_led, ns_red, ns_green,
                         ms_red, ms_green, pa_red, pa_green};
   assign inputs_word = {16'h0000, rel_left_q};

   // Checks
   sequence normal_s;
      clk_en && ctrl_power_on && !ctrl_q[CTRL_BLANK_BIT] && !alarm_active && !ctrl_q[CTRL_SIM_BIT]
      && !power_removal_active && rel_left_q == 16'h0000 && !preset_func_active
      && !info_pending && !teach_remote_active;
   endsequence

   pa_normal_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      normal_s |=> pa_green && !pa_red)
      else $error("Power indicator not steady green in normal state");

   pa_alarm_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && ctrl_power_on && !ctrl_q[CTRL_BLANK_BIT] && alarm_active |=> !pa_green)
      else $error("Power indicator green during alarm");

   pa_removal_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && power_removal_active && !alarm_active && !ctrl_q[CTRL_SIM_BIT] |=> !pa_red)
      else $error("Power indicator red during power removal");

   pa_preset_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && ctrl_power_on && !ctrl_q[CTRL_BLANK_BIT] && !alarm_active && !ctrl_q[CTRL_SIM_BIT]
      && !power_removal_active && rel_left_q == 16'h0000
      && preset_func_active |=> pa_green && pa_red)
      else $error("Home switch function not shown as both lit");

   ms_fatal_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && ctrl_power_on && !ctrl_q[CTRL_BLANK_BIT] && !self_diag_active
      && alarm_active && !alarm_net_resettable |=> ms_red && !ms_green)
      else $error("Module status not steady red on fatal alarm");

   diag_alt_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && ctrl_power_on && !ctrl_q[CTRL_BLANK_BIT] && self_diag_active
      |=> ms_green != ms_red && ns_green != ns_red)
      else $error("Self diagnosis not alternating");

   ns_conn_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && ctrl_power_on && !ctrl_q[CTRL_BLANK_BIT] && !self_diag_active && !ip_duplicate
      && !scanner_timeout && net_online && scanner_connected |=> ns_green && !ns_red)
      else $error("Network status not steady green when connected");

   ns_dup_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && ctrl_power_on && !ctrl_q[CTRL_BLANK_BIT] && !self_diag_active && ip_duplicate
      |=> ns_red && !ns_green)
      else $error("Network status not steady red on duplicate address");

   la_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && ctrl_power_on && !ctrl_q[CTRL_BLANK_BIT] && net_online && !frame_activity
      |=> la_led)
      else $error("Link indicator not lit while online and idle");

   rel_window_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && release_start |=> rel_left_q == $past(rel_time_q))
      else $error("Release window not loaded from release time");
endmodule : sli_indicator
`default_nettype wire

// ===== design/sli_pkg.sv
// Constants and types shared by the status indicator logic
// What this block does
// - Control power on and nothing else active: power/alarm indicator steady green.
// - Alarm active: power/alarm red blinks the alarm count, green off.
// - Torque power removal active: power/alarm green blinks, red off.
// - Information pending: power/alarm green and red double blink together.
// - Teaching or remote operation running: same green-and-red double blink.
// - Interlock released by held home switch: both blink until release time elapses.
// - Home switch input function executing: green and red lit together.
// - Simulation mode: cycle green, red, both, off repeatedly.
// - Network configuration invalid: module status green blinks, red off.
// - Normal operation: module status steady green, red off.
// - Resettable alarm or duplicate address: module status red blinks, green off.
// - Non-resettable alarm: module status steady red, green off.
// - Self-diagnosis: module and network status blink green and red alternately.
// - Online without scanner connection: network green blinks; offline: both off.
// - Scanner connection established online: network status steady green.
// - Scanner connection timed out: network status red blinks.
// - Duplicate IP address: network status steady red.
// - Link indicator off offline, on online idle, blinking with frame traffic.
// - Information condition produces the simultaneous double blink only when no alarm, simulation, removal, release or preset pattern is active.
package sli_pkg;
   localparam int CLK_PERIOD_NS = 25;
   localparam int MS_NS = 1000000;
   localparam int TICK_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BLINK_HALF_MS = 250;
   localparam logic [15:0] HOLD_MS = 16'h03e8;
   localparam logic [15:0] REL_TIME_RST = 16'h03e8;
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] REL_TIME_OFS = 4'h4;
   localparam logic [3:0] STATUS_OFS = 4'h8;
   localparam logic [3:0] INPUTS_OFS = 4'hc;
   localparam int CTRL_SIM_BIT = 0;
   localparam int CTRL_BLANK_BIT = 1;
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam int ALM_PAUSE = 4;
   typedef enum logic [3:0] {
      PA_OFF, PA_GREEN, PA_ALARM, PA_REMOVAL, PA_SIM, PA_RELEASE, PA_PRESET, PA_DOUBLE
   } sli_pa_e;
endpackage : sli_pkg

// ===== design/sli_timebase.sv
// Free-running timebase shared by every blinking indicator pattern and the home switch timers
`timescale 1ns/10ps
`default_nettype none
module sli_timebase
   import sli_pkg::*;
#(
   parameter int TICKS = TICK_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   output logic ms_tick,
   output logic half_tick,
   output logic [2:0] step_q
);
   logic [15:0] cyc_q, cyc_d;
   logic [15:0] ms_q, ms_d;
   logic [2:0] step_d;

   always_comb begin
      cyc_d = cyc_q + 16'h0001;
      ms_d = ms_q;
      step_d = step_q;
      ms_tick = (cyc_q == 16'(TICKS - 1));
      half_tick = ms_tick && (ms_q == 16'(BLINK_HALF_MS - 1));
      if (ms_tick) begin
         cyc_d = 16'h0000;
         ms_d = ms_q + 16'h0001;
      end
      if (half_tick) begin
         ms_d = 16'h0000;
         step_d = step_q + 3'h1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cyc_q <= 16'h0000;
         ms_q <= 16'h0000;
         step_q <= 3'h0;
      end else if (clk_en) begin
         cyc_q <= cyc_d;
         ms_q <= ms_d;
         step_q <= step_d;
      end
   end

   half_step_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && half_tick |=> step_q == $past(step_q) + 3'h1)
      else $error("Pattern step did not advance on half period tick");
endmodule : sli_timebase
`default_nettype wire

// ===== test/status_led_indicator_logic_tb.sv
// Self-checking testbench for the front-panel status indicator logic
`timescale 1ns/10ps
`default_nettype none
module status_led_indicator_logic_tb
   import sli_pkg::*;
;
   localparam int TK = 1;
   localparam int HALF = BLINK_HALF_MS * TK;
   // Longest steady run of any pattern is five half periods, so nine show both states
   localparam int W = 9 * HALF;
   localparam logic [14:0] P = 15'h0001, ALM = 15'h0002, RES = 15'h0004, REM = 15'h0008, INF = 15'h0010;
   localparam logic [14:0] TCH = 15'h0020, PIN = 15'h0040, PRE = 15'h0080, DIAG = 15'h0100, CFG = 15'h0200;
   localparam logic [14:0] DUP = 15'h0400, ON = 15'h0800, CON = 15'h1000, TMO = 15'h2000, FRM = 15'h4000;
   logic sys_clk;
   logic rst_b = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic clk_en = 1'b1;
   logic [31:0] reg_rdata;
   logic [14:0] st = 15'h0000;
   logic [3:0] ac = 4'h1;
   logic pa_green, pa_red, ms_green, ms_red, ns_green, ns_red, la_led;
   logic [6:0] leds;
   int errors = 0;
   int n_checks = 0;
   int on_n[7];
   int off_n[7];
   int eq_n, alt_n;
   assign leds = {la_led, ns_red, ns_green, ms_red, ms_green, pa_red, pa_green};
   sli_indicator #(.TICKS(TK)) i_dut (
      .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ctrl_power_on(st[0]), .alarm_active(st[1]),
      .alarm_count(ac), .alarm_net_resettable(st[2]), .power_removal_active(st[3]), .info_pending(st[4]),
      .teach_remote_active(st[5]), .home_preset_sw_pin(st[6]), .preset_func_active(st[7]),
      .self_diag_active(st[8]), .net_config_invalid(st[9]), .ip_duplicate(st[10]), .net_online(st[11]),
      .scanner_connected(st[12]), .scanner_timeout(st[13]), .frame_activity(st[14]),
      .pa_green(pa_green), .pa_red(pa_red), .ms_green(ms_green), .ms_red(ms_red),
      .ns_green(ns_green), .ns_red(ns_red), .la_led(la_led));
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   task automatic test_done();
      $display("Checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd
   task automatic apply(input logic [14:0] in, input logic [3:0] a);
      @(posedge sys_clk);
      st <= in;
      ac <= a;
      repeat (3) @(posedge sys_clk);
   endtask : apply
   // Counts lit and unlit cycles of every indicator, and pa in-phase and ms/ns alternating cycles, over a window
   task automatic watch(input int n);
      eq_n = 0;
      alt_n = 0;
      for (int i = 0; i < 7; i++) begin
         on_n[i] = 0;
         off_n[i] = 0;
      end
      repeat (n) begin
         @(posedge sys_clk);
         #1;
         for (int i = 0; i < 7; i++) begin
            if (leds[i] === 1'b1) on_n[i]++;
            else if (leds[i] === 1'b0) off_n[i]++;
         end
         if (pa_green === pa_red) eq_n++;
         if ((ms_green ^ ms_red) === 1'b1 && (ns_green ^ ns_red) === 1'b1) alt_n++;
      end
   endtask : watch
   // 0 unlit, 1 lit, 2 blinking, 3 unknown seen
   function automatic logic [3:0] code(input int i, input int n);
      if (on_n[i] == n) return 4'h1;
      if (off_n[i] == n) return 4'h0;
      return (on_n[i] + off_n[i] == n) ? 4'h2 : 4'h3;
   endfunction : code
   // Expected codes one nibble per indicator, pa_green in the lowest nibble
   task automatic row(input logic [14:0] in, input logic [3:0] a, input logic [27:0] e, input int mode);
      apply(in, a);
      watch(W);
      for (int i = 0; i < 7; i++) check($sformatf("led %0d of %h", i, in), {28'h0, code(i, W)}, {28'h0, e[4*i+:4]});
      if (mode == 1) check("pa in phase", eq_n, W);
      if (mode == 2) check("ms ns alternate", alt_n, W);
   endtask : row
   task automatic t_regs();
      logic [31:0] d;
      apply(P, 4'h1);
      rd(REL_TIME_OFS, d);
      check("rel time reset", d, 32'h000003e8);
      rd(CTRL_OFS, d);
      check("ctrl reset", d, 32'h0);
      @(posedge sys_clk);
      #1;
      check("rdata after read", reg_rdata, 32'h0);
      wr(4'h2, 32'hffffffff);
      rd(4'h2, d);
      check("unmapped", d, 32'h0);
      wr(CTRL_OFS, 32'hffffffff);
      rd(CTRL_OFS, d);
      check("ctrl used bits", d, 32'h00000003);
      wr(CTRL_OFS, 32'h0);
      wr(STATUS_OFS, 32'hffffffff);
      rd(STATUS_OFS, d);
      check("status power only", d, 32'h00010005);
      // With the clock enable low a write must not be taken
      @(posedge sys_clk);
      clk_en <= 1'b0;
      wr(CTRL_OFS, 32'h00000002);
      repeat (2) @(posedge sys_clk);
      #1;
      check("leds while frozen", {25'h0, leds}, 32'h00000005);
      @(posedge sys_clk);
      clk_en <= 1'b1;
      rd(CTRL_OFS, d);
      check("ctrl write while frozen", d, 32'h0);
   endtask : t_regs
   task automatic t_net();
      row(P, 4'h1, 28'h0000101, 0);
      row(P | ON, 4'h1, 28'h1020101, 0);
      row(P | ON | CON | FRM, 4'h1, 28'h2010101, 0);
      row(P | ON | TMO, 4'h1, 28'h1200101, 0);
      row(P | ON | CON | DUP, 4'h1, 28'h1102001, 0);
      row(P | CFG, 4'h1, 28'h0000201, 0);
      row(P | ON | DIAG, 4'h1, 28'h1222201, 2);
   endtask : t_net
   task automatic t_alarm();
      int pulses;
      logic was_red;
      row(P | ON | CON | ALM | RES, 4'h2, 28'h1012020, 0);
      row(P | ALM, 4'h3, 28'h0001020, 0);
      row(P | ALM | RES | INF | REM | PRE, 4'h1, 28'h0002020, 0);
      row(P, 4'h1, 28'h0000101, 0);
      // From a fresh alarm, 2N+3 half periods hold exactly N red flashes
      @(posedge sys_clk);
      st <= P | ALM;
      ac <= 4'h3;
      pulses = 0;
      was_red = 1'b0;
      repeat (9 * HALF) begin
         @(posedge sys_clk);
         #1;
         if (pa_red === 1'b1 && was_red !== 1'b1) pulses++;
         was_red = pa_red;
      end
      check("alarm flashes", pulses, 3);
   endtask : t_alarm
   task automatic t_power();
      row(P | REM, 4'h1, 28'h0000102, 0);
      row(P | INF, 4'h1, 28'h0000122, 1);
      row(P | TCH, 4'h1, 28'h0000122, 1);
      row(P | PRE, 4'h1, 28'h0000111, 0);
      row(15'h0000, 4'h1, 28'h0000000, 0);
   endtask : t_power
   function automatic logic [1:0] nxt(input logic [1:0] p);
      case (p)
         2'b10: return 2'b01;
         2'b01: return 2'b11;
         2'b11: return 2'b00;
         default: return 2'b10;
      endcase
   endfunction : nxt
   task automatic t_sim();
      logic [31:0] d;
      logic [1:0] prev;
      int chg;
      chg = 0;
      wr(CTRL_OFS, 32'h00000001);
      apply(P, 4'h1);
      rd(STATUS_OFS, d);
      check("sim code", {28'h0, d[19:16]}, 32'(PA_SIM));
      prev = {pa_green, pa_red};
      repeat (4 * HALF + 100) begin
         @(posedge sys_clk);
         #1;
         if ({pa_green, pa_red} !== prev) begin
            check("sim order", {30'h0, pa_green, pa_red}, {30'h0, nxt(prev)});
            chg++;
            prev = {pa_green, pa_red};
         end
      end
      check("sim steps", chg >= 4, 1);
      wr(CTRL_OFS, 32'h00000002);
      row(P | ON | CON, 4'h1, 28'h0000000, 0);
      wr(CTRL_OFS, 32'h0);
   endtask : t_sim
   task automatic t_home();
      logic [31:0] d;
      wr(REL_TIME_OFS, 32'h00000320);
      apply(P | PIN, 4'h1);
      repeat (int'(HOLD_MS) * TK + 20) @(posedge sys_clk);
      st <= P;
      repeat (3) @(posedge sys_clk);
      rd(STATUS_OFS, d);
      check("release code", {28'h0, d[19:16]}, 32'(PA_RELEASE));
      rd(INPUTS_OFS, d);
      check("release left", d > 32'h0 && d <= 32'h320, 1);
      watch(2 * HALF);
      check("release green", code(0, 2 * HALF), 4'h2);
      check("release red", code(1, 2 * HALF), 4'h2);
      check("release phase", eq_n, 2 * HALF);
      repeat (800 * TK) @(posedge sys_clk);
      watch(100);
      check("after release", {code(1, 100), code(0, 100)}, 8'h01);
   endtask : t_home
   initial begin
      #(25 * 60000);
      errors++;
      test_done();
   end
   initial begin
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_regs();
      t_net();
      t_alarm();
      t_power();
      t_sim();
      t_home();
      test_done();
   end
endmodule : status_led_indicator_logic_tb
`default_nettype wire
